// ===== rtl/csrm_params.svh
// Constants of the climate sensor register map
`ifndef CSRM_PARAMS_SVH
`define CSRM_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CSRM_OFF_TEMP_LO 8'h00
`define CSRM_OFF_TEMP_HI 8'h01
`define CSRM_OFF_HUMID_LO 8'h02
`define CSRM_OFF_HUMID_HI 8'h03
`define CSRM_OFF_STATUS 8'h04
`define CSRM_OFF_TEMP_PEAK 8'h05
`define CSRM_OFF_HUMID_PEAK 8'h06
`define CSRM_OFF_EVT_EN 8'h07
`define CSRM_OFF_TEMP_LIM_LO 8'h0A
`define CSRM_OFF_TEMP_LIM_HI 8'h0B
`define CSRM_OFF_HUMID_LIM_LO 8'h0C
`define CSRM_OFF_HUMID_LIM_HI 8'h0D
`define CSRM_OFF_ALERT_CFG 8'h0E
`define CSRM_OFF_CONV_CFG 8'h0F
`define CSRM_OFF_ID_FIRST 8'hFC
`define CSRM_OFF_MAKER_HI 8'hFD
`define CSRM_OFF_PART_LO 8'hFE
`define CSRM_OFF_PART_HI 8'hFF

// ****************************************
// Field positions and codes
// ****************************************
`define CSRM_DRDY_BIT 7
`define CSRM_TH_BIT 6
`define CSRM_TL_BIT 5
`define CSRM_HH_BIT 4
`define CSRM_HL_BIT 3
`define CSRM_SOFT_RST_BIT 7
`define CSRM_AUTO_HI 6
`define CSRM_AUTO_LO 4
`define CSRM_TRES_HI 7
`define CSRM_TRES_LO 6
`define CSRM_HRES_HI 5
`define CSRM_HRES_LO 4
`define CSRM_RES_11 2'b01
`define CSRM_RES_9 2'b10
`define CSRM_RES_11_DROP 3
`define CSRM_RES_9_DROP 5
`define CSRM_PAD_BITS 2

// ****************************************
// Reset values and sizes
// ****************************************
`define CSRM_ZERO_BYTE 8'h00
`define CSRM_LIMIT_HI_RST 8'h7F
`define CSRM_CFG_DEPTH 9
`define CSRM_CFG_AW 4

`endif

// ===== rtl/csrm_pkg.sv
// Types shared by the climate sensor register map
package csrm_pkg;
    typedef logic [7:0] csrm_byte_t;
    typedef enum logic [3:0] {
        CSRM_SRC_NONE,
        CSRM_SRC_TLO,
        CSRM_SRC_THI,
        CSRM_SRC_HLO,
        CSRM_SRC_HHI,
        CSRM_SRC_STAT,
        CSRM_SRC_TPEAK,
        CSRM_SRC_HPEAK,
        CSRM_SRC_CFG,
        CSRM_SRC_ID
    } csrm_src_e;
endpackage

// ===== rtl/csrm_cfg_mem.sv
// Byte store for the configuration registers with registered read
`timescale 1ns/1ps
`default_nettype none
`include "csrm_params.svh"
module csrm_cfg_mem #(
    parameter int DEPTH = 9,
    parameter int AW = 4,
    parameter logic [DEPTH*8-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire csrm_pkg::csrm_byte_t wdata,
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output csrm_pkg::csrm_byte_t rdata,
    output logic [DEPTH*8-1:0] flat
);
    import csrm_pkg::*;

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("csrm_cfg_mem depth exceeds address range");
    end

    // ****************************************
    // Storage, one byte per entry
    // ****************************************
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flat[i*8 +: 8] <= INIT[i*8 +: 8];
            end else if (clr) begin
                flat[i*8 +: 8] <= INIT[i*8 +: 8];
            end else if (we && (waddr == AW'(i))) begin
                flat[i*8 +: 8] <= wdata;
            end
        end
    end

    // ****************************************
    // Registered read port
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `CSRM_ZERO_BYTE;
        end else if (re) begin
            rdata <= (int'(raddr) < DEPTH) ? flat[int'(raddr)*8 +: 8] : `CSRM_ZERO_BYTE;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/csrm_regmap.sv
// Register map of the climate sensor behind the serial controller's byte port
`timescale 1ns/1ps
`default_nettype none
`include "csrm_params.svh"
module csrm_regmap #(
    parameter int CONV_W = 14,
    parameter int RESULT_W = 16,
    parameter logic [7:0] MAKER_LO = 8'hA5,
    parameter logic [7:0] MAKER_HI = 8'h5A,
    parameter logic [7:0] PART_LO = 8'h3C,
    parameter logic [7:0] PART_HI = 8'hC3
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ptr_we,
    input wire csrm_pkg::csrm_byte_t ptr_byte,
    input wire logic wr_we,
    input wire csrm_pkg::csrm_byte_t wr_byte,
    input wire logic rd_req,
    input wire logic conv_valid,
    input wire logic conv_is_temp,
    input wire logic [CONV_W-1:0] conv_code,
    output logic ptr_ack,
    output logic ptr_nack,
    output logic wr_ack,
    output logic wr_nack,
    output logic rd_valid,
    output csrm_pkg::csrm_byte_t rd_data,
    output logic auto_mode,
    output logic soft_rst
);
    import csrm_pkg::*;
    // Identity parameters above hold arbitrary values

    if (RESULT_W != CONV_W + `CSRM_PAD_BITS || CONV_W <= `CSRM_RES_9_DROP) begin : g_chk
        $error("csrm_regmap result width must be code width plus two");
    end

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_n, srst_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            srst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            srst_n <= rst_meta_n;
        end
    end

    // ****************************************
    // State
    // ****************************************
    csrm_byte_t ptr, status, status_snap, temp_peak, humid_peak, temp_hi_shadow, humid_hi_shadow, cfg_rdata;
    logic [RESULT_W-1:0] temp_res, humid_res;
    logic [`CSRM_CFG_DEPTH*8-1:0] cfg_flat;
    csrm_src_e rd_src;
    logic [1:0] rd_id_sel;
    logic rd_pend;

    localparam logic [`CSRM_CFG_DEPTH*8-1:0] CFG_INIT = {`CSRM_ZERO_BYTE, `CSRM_ZERO_BYTE, `CSRM_LIMIT_HI_RST,
        `CSRM_ZERO_BYTE, `CSRM_LIMIT_HI_RST, `CSRM_ZERO_BYTE, `CSRM_ZERO_BYTE, `CSRM_ZERO_BYTE, `CSRM_ZERO_BYTE};

    // ****************************************
    // Configuration fields
    // ****************************************
    function automatic csrm_byte_t cfg_at(input csrm_byte_t off, input logic [`CSRM_CFG_DEPTH*8-1:0] f);
        cfg_at = f[int'(off - `CSRM_OFF_EVT_EN)*8 +: 8];
    endfunction
    wire csrm_byte_t evt_en = cfg_at(`CSRM_OFF_EVT_EN, cfg_flat);
    wire csrm_byte_t alert_cfg = cfg_at(`CSRM_OFF_ALERT_CFG, cfg_flat);
    wire csrm_byte_t conv_cfg = cfg_at(`CSRM_OFF_CONV_CFG, cfg_flat);
    wire csrm_byte_t t_lim_lo = cfg_at(`CSRM_OFF_TEMP_LIM_LO, cfg_flat);
    wire csrm_byte_t t_lim_hi = cfg_at(`CSRM_OFF_TEMP_LIM_HI, cfg_flat);
    wire csrm_byte_t h_lim_lo = cfg_at(`CSRM_OFF_HUMID_LIM_LO, cfg_flat);
    wire csrm_byte_t h_lim_hi = cfg_at(`CSRM_OFF_HUMID_LIM_HI, cfg_flat);
    wire logic auto_on = |alert_cfg[`CSRM_AUTO_HI:`CSRM_AUTO_LO];

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic addr_used(input csrm_byte_t a);
        addr_used = (a <= `CSRM_OFF_CONV_CFG) || (a >= `CSRM_OFF_ID_FIRST);
    endfunction
    wire logic new_ptr_ok = addr_used(ptr_byte);
    wire logic wr_ok = wr_we && !ptr_we && ptr >= `CSRM_OFF_TEMP_PEAK && ptr <= `CSRM_OFF_CONV_CFG;
    wire logic wr_tpeak = wr_ok && ptr == `CSRM_OFF_TEMP_PEAK;
    wire logic wr_hpeak = wr_ok && ptr == `CSRM_OFF_HUMID_PEAK;
    wire logic wr_cfg = wr_ok && ptr >= `CSRM_OFF_EVT_EN;
    wire logic rd_cfg = rd_req && ptr >= `CSRM_OFF_EVT_EN && ptr <= `CSRM_OFF_CONV_CFG;
    wire logic [`CSRM_CFG_AW-1:0] cfg_idx = `CSRM_CFG_AW'(ptr - `CSRM_OFF_EVT_EN);
    wire logic soft_req = wr_ok && ptr == `CSRM_OFF_ALERT_CFG && wr_byte[`CSRM_SOFT_RST_BIT];
    wire csrm_src_e next_src = !rd_req ? CSRM_SRC_NONE :
        ptr == `CSRM_OFF_TEMP_LO ? CSRM_SRC_TLO :
        ptr == `CSRM_OFF_TEMP_HI ? CSRM_SRC_THI :
        ptr == `CSRM_OFF_HUMID_LO ? CSRM_SRC_HLO :
        ptr == `CSRM_OFF_HUMID_HI ? CSRM_SRC_HHI :
        ptr == `CSRM_OFF_STATUS ? CSRM_SRC_STAT :
        ptr == `CSRM_OFF_TEMP_PEAK ? CSRM_SRC_TPEAK :
        ptr == `CSRM_OFF_HUMID_PEAK ? CSRM_SRC_HPEAK :
        ptr <= `CSRM_OFF_CONV_CFG ? CSRM_SRC_CFG :
        ptr >= `CSRM_OFF_ID_FIRST ? CSRM_SRC_ID : CSRM_SRC_NONE;
    wire logic rd_status = rd_req && ptr == `CSRM_OFF_STATUS;
    wire logic rd_result = rd_req && ptr <= `CSRM_OFF_HUMID_HI;

    // ****************************************
    // Conversion capture
    // ****************************************
    function automatic logic [CONV_W-1:0] trim(input logic [CONV_W-1:0] c, input logic [1:0] res);
        logic [CONV_W-1:0] m;
        m = '1;
        if (res == `CSRM_RES_11) begin
            m = m << `CSRM_RES_11_DROP;
        end else if (res == `CSRM_RES_9) begin
            m = m << `CSRM_RES_9_DROP;
        end
        trim = c & m;
    endfunction
    wire logic [1:0] t_res = conv_cfg[`CSRM_TRES_HI:`CSRM_TRES_LO];
    wire logic [1:0] h_res = conv_cfg[`CSRM_HRES_HI:`CSRM_HRES_LO];
    wire logic [RESULT_W-1:0] next_temp = {trim(conv_code, t_res), `CSRM_PAD_BITS'(0)};
    wire logic [RESULT_W-1:0] next_humid = {trim(conv_code, h_res), `CSRM_PAD_BITS'(0)};
    wire logic t_conv = conv_valid && conv_is_temp;
    wire logic h_conv = conv_valid && !conv_is_temp;
    wire csrm_byte_t t_top = next_temp[RESULT_W-1 -: 8];
    wire csrm_byte_t h_top = next_humid[RESULT_W-1 -: 8];
    wire logic t_peak_up = t_conv && !auto_on && t_top > temp_peak;
    wire logic h_peak_up = h_conv && !auto_on && h_top > humid_peak;
    wire csrm_byte_t status_set = {conv_valid,
        t_conv && evt_en[`CSRM_TH_BIT] && t_top > t_lim_hi,
        t_conv && evt_en[`CSRM_TL_BIT] && t_top < t_lim_lo,
        h_conv && evt_en[`CSRM_HH_BIT] && h_top > h_lim_hi,
        h_conv && evt_en[`CSRM_HL_BIT] && h_top < h_lim_lo, 3'b000};
    wire csrm_byte_t status_clr = rd_status ? 8'hFF : (rd_result ? 8'h80 : 8'h00);

    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            temp_res <= '0;
            humid_res <= '0;
            status <= `CSRM_ZERO_BYTE;
            temp_peak <= `CSRM_ZERO_BYTE;
            humid_peak <= `CSRM_ZERO_BYTE;
        end else if (soft_rst) begin
            temp_res <= '0;
            humid_res <= '0;
            status <= `CSRM_ZERO_BYTE;
            temp_peak <= `CSRM_ZERO_BYTE;
            humid_peak <= `CSRM_ZERO_BYTE;
        end else begin
            temp_res <= t_conv ? next_temp : temp_res;
            humid_res <= h_conv ? next_humid : humid_res;
            status <= (status & ~status_clr) | status_set;
            temp_peak <= t_peak_up ? t_top : (wr_tpeak ? wr_byte : temp_peak);
            humid_peak <= h_peak_up ? h_top : (wr_hpeak ? wr_byte : humid_peak);
        end
    end

    // ****************************************
    // Pointer, answers and read pipeline
    // ****************************************
    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            ptr <= `CSRM_ZERO_BYTE;
            ptr_ack <= 1'b0;
            ptr_nack <= 1'b0;
            wr_ack <= 1'b0;
            wr_nack <= 1'b0;
            rd_pend <= 1'b0;
            rd_src <= CSRM_SRC_NONE;
            rd_id_sel <= 2'b00;
            rd_valid <= 1'b0;
            rd_data <= `CSRM_ZERO_BYTE;
            temp_hi_shadow <= `CSRM_ZERO_BYTE;
            humid_hi_shadow <= `CSRM_ZERO_BYTE;
            status_snap <= `CSRM_ZERO_BYTE;
            auto_mode <= 1'b0;
            soft_rst <= 1'b0;
        end else begin
            if (ptr_we) begin
                ptr <= ptr_byte;
            end else if (wr_we || rd_req) begin
                ptr <= 8'(ptr + 8'h01);
            end
            ptr_ack <= ptr_we && new_ptr_ok;
            ptr_nack <= ptr_we && !new_ptr_ok;
            wr_ack <= !ptr_we && wr_ok;
            wr_nack <= !ptr_we && wr_we && !wr_ok;
            rd_pend <= rd_req;
            rd_src <= next_src;
            rd_id_sel <= ptr[1:0];
            if (rd_req && ptr == `CSRM_OFF_TEMP_LO) begin
                temp_hi_shadow <= temp_res[RESULT_W-1 -: 8];
            end
            if (rd_req && ptr == `CSRM_OFF_HUMID_LO) begin
                humid_hi_shadow <= humid_res[RESULT_W-1 -: 8];
            end
            if (rd_status) begin
                status_snap <= status;
            end
            rd_valid <= rd_pend;
            if (rd_pend) begin
                case (rd_src)
                    CSRM_SRC_TLO: rd_data <= temp_res[7:0];
                    CSRM_SRC_THI: rd_data <= temp_hi_shadow;
                    CSRM_SRC_HLO: rd_data <= humid_res[7:0];
                    CSRM_SRC_HHI: rd_data <= humid_hi_shadow;
                    CSRM_SRC_STAT: rd_data <= status_snap;
                    CSRM_SRC_TPEAK: rd_data <= temp_peak;
                    CSRM_SRC_HPEAK: rd_data <= humid_peak;
                    CSRM_SRC_CFG: rd_data <= cfg_rdata;
                    CSRM_SRC_ID: rd_data <= rd_id_sel == 2'b00 ? MAKER_LO : rd_id_sel == 2'b01 ? MAKER_HI :
                        rd_id_sel == 2'b10 ? PART_LO : PART_HI;
                    default: rd_data <= `CSRM_ZERO_BYTE;
                endcase
            end
            auto_mode <= auto_on;
            soft_rst <= soft_req;
        end
    end

    csrm_cfg_mem #(.DEPTH(`CSRM_CFG_DEPTH), .AW(`CSRM_CFG_AW), .INIT(CFG_INIT)) csrm_cfg_mem_inst (
        .clk(sys_clk),
        .rst_n(srst_n),
        .clr(soft_rst),
        .we(wr_cfg),
        .waddr(cfg_idx),
        .wdata(wr_byte),
        .re(rd_cfg),
        .raddr(cfg_idx),
        .rdata(cfg_rdata),
        .flat(cfg_flat)
    );

    // ****************************************
    // Checks
    // ****************************************
    AST_TEMP_PAD: assert property (@(posedge sys_clk) disable iff (!srst_n)
        temp_res[1:0] == 2'b00) else $error("temperature pad bits not zero");
    AST_RES_TRIM: assert property (@(posedge sys_clk) disable iff (!srst_n)
        t_conv && !soft_rst && t_res == `CSRM_RES_11 |=> temp_res[4:2] == 3'b000)
        else $error("11-bit resolution not trimmed");
    AST_PEAK_HOLD: assert property (@(posedge sys_clk) disable iff (!srst_n)
        auto_on && !wr_tpeak && !soft_rst |=> $stable(temp_peak)) else $error("peak moved in auto mode");
    AST_CODE_STORE: assert property (@(posedge sys_clk) disable iff (!srst_n)
        t_conv && !soft_rst && t_res == 2'b00 |=> temp_res[RESULT_W-1:2] == $past(conv_code))
        else $error("temperature code not stored unscaled");
    AST_PTR_STEP: assert property (@(posedge sys_clk) disable iff (!srst_n)
        rd_req && !ptr_we |=> ptr == 8'($past(ptr) + 8'h01)) else $error("pointer did not advance");
    AST_PTR_NACK: assert property (@(posedge sys_clk) disable iff (!srst_n)
        ptr_we && !addr_used(ptr_byte) |=> ptr_nack && !ptr_ack) else $error("unused pointer not refused");
    AST_RO_WRITE: assert property (@(posedge sys_clk) disable iff (!srst_n)
        wr_we && !ptr_we && !conv_valid && !soft_rst && ptr <= `CSRM_OFF_HUMID_HI |=> wr_nack && $stable(temp_res))
        else $error("result register accepted a write");
    AST_RD_LAT: assert property (@(posedge sys_clk) disable iff (!srst_n)
        rd_req |-> ##2 rd_valid) else $error("read answer late");
    COV_PTR_NACK: cover property (@(posedge sys_clk) disable iff (!srst_n) ptr_nack);
    COV_READ: cover property (@(posedge sys_clk) disable iff (!srst_n) rd_req ##1 rd_req ##1 rd_valid);
    COV_PEAK: cover property (@(posedge sys_clk) disable iff (!srst_n) t_peak_up);
    COV_SOFT: cover property (@(posedge sys_clk) disable iff (!srst_n) soft_rst);
endmodule
`default_nettype wire

// ===== test/csrm_ctrl_model.sv
// Serial controller model driving the register map's byte ports
`timescale 1ns/1ps
`default_nettype none
module csrm_ctrl_model (
    input wire logic sys_clk,
    output var logic ptr_we,
    output var csrm_pkg::csrm_byte_t ptr_byte,
    output var logic wr_we,
    output var csrm_pkg::csrm_byte_t wr_byte,
    output var logic rd_req,
    input wire logic ptr_ack,
    input wire logic ptr_nack,
    input wire logic wr_ack,
    input wire logic wr_nack,
    input wire logic rd_valid,
    input wire csrm_pkg::csrm_byte_t rd_data
);
    import csrm_pkg::*;
    initial begin
        ptr_we = 1'b0;
        ptr_byte = 8'h00;
        wr_we = 1'b0;
        wr_byte = 8'h00;
        rd_req = 1'b0;
    end
    // ****************************************
    // Byte transfers, answer awaited under a bound
    // ****************************************
    task automatic put_ptr(input csrm_byte_t a, output logic [1:0] resp);
        int i;
        @(posedge sys_clk);
        #1;
        ptr_we = 1'b1;
        ptr_byte = a;
        @(posedge sys_clk);
        #1;
        ptr_we = 1'b0;
        ptr_byte = ~a;
        i = 0;
        while (ptr_ack !== 1'b1 && ptr_nack !== 1'b1 && i < 4) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        resp = {ptr_ack, ptr_nack};
    endtask
    task automatic put_byte(input csrm_byte_t d, output logic [1:0] resp);
        int i;
        @(posedge sys_clk);
        #1;
        wr_we = 1'b1;
        wr_byte = d;
        @(posedge sys_clk);
        #1;
        wr_we = 1'b0;
        wr_byte = ~d;
        i = 0;
        while (wr_ack !== 1'b1 && wr_nack !== 1'b1 && i < 4) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        resp = {wr_ack, wr_nack};
    endtask
    task automatic get_byte(output csrm_byte_t d);
        int i;
        @(posedge sys_clk);
        #1;
        rd_req = 1'b1;
        @(posedge sys_clk);
        #1;
        rd_req = 1'b0;
        i = 0;
        while (rd_valid !== 1'b1 && i < 4) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
    endtask
endmodule
`default_nettype wire

// ===== test/csrm_regmap_bench.sv
// Self-checking bench for the climate sensor register map
`timescale 1ns/1ps
`default_nettype none
module csrm_regmap_bench;
    import csrm_pkg::*;
    logic sys_clk, rst_n, ptr_we, wr_we, rd_req, conv_valid, conv_is_temp;
    csrm_byte_t ptr_byte, wr_byte, rd_data;
    logic [13:0] conv_code;
    logic ptr_ack, ptr_nack, wr_ack, wr_nack, rd_valid, auto_mode, soft_rst;
    int n_fail, samples_checked, rst_seen;
    // Identity bytes are arbitrary
    csrm_regmap #(.MAKER_LO(8'h11), .MAKER_HI(8'h22), .PART_LO(8'h33), .PART_HI(8'h44)) csrm_regmap_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .ptr_we(ptr_we), .ptr_byte(ptr_byte), .wr_we(wr_we),
        .wr_byte(wr_byte), .rd_req(rd_req), .conv_valid(conv_valid), .conv_is_temp(conv_is_temp),
        .conv_code(conv_code), .ptr_ack(ptr_ack), .ptr_nack(ptr_nack), .wr_ack(wr_ack), .wr_nack(wr_nack),
        .rd_valid(rd_valid), .rd_data(rd_data), .auto_mode(auto_mode), .soft_rst(soft_rst));
    csrm_ctrl_model csrm_ctrl_model_inst (
        .sys_clk(sys_clk), .ptr_we(ptr_we), .ptr_byte(ptr_byte), .wr_we(wr_we), .wr_byte(wr_byte),
        .rd_req(rd_req), .ptr_ack(ptr_ack), .ptr_nack(ptr_nack), .wr_ack(wr_ack), .wr_nack(wr_nack),
        .rd_valid(rd_valid), .rd_data(rd_data));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (soft_rst === 1'b1) rst_seen++;
    end
    // ****************************************
    // Helpers
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic go(input csrm_byte_t a, input logic [1:0] exp);
        logic [1:0] r;
        csrm_ctrl_model_inst.put_ptr(a, r);
        check("pointer answer", {14'h0, r}, {14'h0, exp});
    endtask
    task automatic wr(input csrm_byte_t d, input logic [1:0] exp);
        logic [1:0] r;
        csrm_ctrl_model_inst.put_byte(d, r);
        check("write answer", {14'h0, r}, {14'h0, exp});
    endtask
    task automatic rd(input string what, input csrm_byte_t exp);
        csrm_byte_t d;
        csrm_ctrl_model_inst.get_byte(d);
        check(what, {8'h0, d}, {8'h0, exp});
    endtask
    task automatic conv(input logic [13:0] code, input logic is_temp);
        @(posedge sys_clk);
        #1;
        conv_valid = 1'b1;
        conv_is_temp = is_temp;
        conv_code = code;
        @(posedge sys_clk);
        #1;
        conv_valid = 1'b0;
        conv_code = ~code;
        @(posedge sys_clk);
        #1;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_map();
        for (int a = 0; a < 16; a++) begin
            go(8'(a), 2'b10);
            rd("reset value", (a == 11 || a == 13) ? 8'h7F : 8'h00);
        end
        go(8'h10, 2'b01);
        go(8'hFB, 2'b01);
        go(8'hFC, 2'b10);
        rd("maker low", 8'h11);
        rd("maker high", 8'h22);
        rd("part low", 8'h33);
        rd("part high", 8'h44);
    endtask
    task automatic t_temp_result();
        conv(14'h1234, 1'b1);
        go(8'h04, 2'b10);
        rd("status after conversion", 8'h80);
        go(8'h00, 2'b10);
        rd("temp low", 8'hD0);
        rd("temp high", 8'h48);
        rd("humid low", 8'h00);
        go(8'h05, 2'b10);
        rd("temp peak", 8'h48);
        go(8'h07, 2'b10);
        wr(8'h78, 2'b10);
        conv(14'h3000, 1'b0);
        go(8'h04, 2'b10);
        rd("status after humidity", 8'h90);
        go(8'h04, 2'b10);
        rd("status cleared by read", 8'h00);
        go(8'h02, 2'b10);
        rd("humid low after conversion", 8'h00);
        rd("humid high after conversion", 8'hC0);
        go(8'h06, 2'b10);
        rd("humid peak", 8'hC0);
    endtask
    task automatic t_read_only_and_burst();
        go(8'h00, 2'b10);
        wr(8'h5A, 2'b01);
        wr(8'hA5, 2'b01);
        go(8'h00, 2'b10);
        rd("temp low kept", 8'hD0);
        rd("temp high kept", 8'h48);
        go(8'h0A, 2'b10);
        wr(8'h12, 2'b10);
        wr(8'h34, 2'b10);
        go(8'h0A, 2'b10);
        rd("burst first", 8'h12);
        rd("burst second", 8'h34);
    endtask
    task automatic t_auto_peak();
        go(8'h0E, 2'b10);
        wr(8'h10, 2'b10);
        @(posedge sys_clk);
        #1;
        check("auto mode on", {15'h0, auto_mode}, 16'h1);
        conv(14'h3FFF, 1'b1);
        go(8'h05, 2'b10);
        rd("peak held in auto mode", 8'h48);
        go(8'h0E, 2'b10);
        wr(8'h00, 2'b10);
        @(posedge sys_clk);
        #1;
        check("auto mode off", {15'h0, auto_mode}, 16'h0);
    endtask
    task automatic t_resolution();
        logic [15:0] exp [4] = '{16'hFFFC, 16'hFFE0, 16'hFF80, 16'hFFFC};
        for (int m = 0; m < 4; m++) begin
            go(8'h0F, 2'b10);
            wr({2'(m), 6'h00}, 2'b10);
            conv(14'h3FFF, 1'b1);
            go(8'h00, 2'b10);
            rd("trimmed low", exp[m][7:0]);
            rd("trimmed high", exp[m][15:8]);
        end
    endtask
    task automatic t_soft_reset();
        go(8'h0E, 2'b10);
        wr(8'h80, 2'b10);
        repeat (2) @(posedge sys_clk);
        #1;
        check("soft reset pulses", 16'(rst_seen), 16'h1);
        go(8'h0B, 2'b10);
        rd("limit after soft reset", 8'h7F);
        go(8'h00, 2'b10);
        rd("result after soft reset", 8'h00);
        go(8'h0F, 2'b10);
        rd("config after soft reset", 8'h00);
        go(8'h04, 2'b10);
        rd("status after soft reset", 8'h00);
    endtask
    initial begin
        n_fail = 0;
        samples_checked = 0;
        rst_seen = 0;
        rst_n = 1'b0;
        conv_valid = 1'b0;
        conv_is_temp = 1'b0;
        conv_code = 14'h0000;
        repeat (2) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset_map();
        t_temp_result();
        t_read_only_and_burst();
        t_auto_peak();
        t_resolution();
        t_soft_reset();
        end_sim();
    end
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
